// [rtl/vip_defs.svh]
// constants of the vectored interrupt prioritizer: offsets, fields, maps
// assumes inclusion by bare name from the package only
`ifndef VIP_DEFS_SVH
`define VIP_DEFS_SVH

// capacity of the controller
`define VIP_MAX_IRQ       96
`define VIP_MAX_VEC       64
`define VIP_VEC_W         6
`define VIP_NUM_EXT       5

// one priority register holds four vector slots of eight bits each
`define VIP_SLOT_W        8
`define VIP_PRI_LSB       2
`define VIP_PRI_W         3
`define VIP_SUB_LSB       0
`define VIP_SUB_W         2
`define VIP_FLAG_REG_W    32

// external inputs sit at requests 3, 7, 11, 15 and 19
`define VIP_EXT_FIRST     3
`define VIP_EXT_STRIDE    4

// request to vector map, beyond the one-to-one range
`define VIP_IRQ_DIRECT_LAST 23
`define VIP_IRQ_SPI1_LAST   25
`define VIP_IRQ_SHR24_LAST  28
`define VIP_IRQ_TW1_LAST    31
`define VIP_IRQ_PINCHG      32
`define VIP_VEC_SPI1        23
`define VIP_VEC_SHR24       24
`define VIP_VEC_TW1         25
`define VIP_VEC_PINCHG      26

// sources listed in the map are present by default
`define VIP_PRESENT_DEF   96'h0000_0001_FFFF_FFFF

// reset values
`define VIP_ADDR_RST      32'h0000_0000

`endif

// [rtl/vip_pkg.sv]
// types of the vectored interrupt prioritizer
// assumes vip_defs.svh is on the include path
package vip_pkg;
`include "vip_defs.svh"

	// registered state of the top module
	typedef struct packed {
		logic [`VIP_MAX_IRQ-1:0] flags;
		logic                    req;
		logic [`VIP_VEC_W-1:0]   vec;
		logic [`VIP_PRI_W-1:0]   pri;
		logic [`VIP_SUB_W-1:0]   sub;
		logic [31:0]             addr;
		logic                    shadow;
	} vip_state_t;

	// registered state of the external edge detector
	typedef struct packed {
		logic [`VIP_NUM_EXT-1:0] prev;
		logic [`VIP_NUM_EXT-1:0] evt;
		logic                    armed;
	} vip_ext_state_t;

endpackage : vip_pkg

// [rtl/vip_ext_edge.sv]
// edge detector for the external interrupt inputs, polarity per input
// assumes inputs synchronous to the system clock
module vip_ext_edge
	import vip_pkg::*;
#(
	parameter int NUM_EXT = `VIP_NUM_EXT
) (
	// clock and reset
	input  wire logic               clk_in,
	input  wire logic               rst_n_in,
	// pins and polarity, 1 selects the rising edge
	input  wire logic [NUM_EXT-1:0] ext_in,
	input  wire logic [NUM_EXT-1:0] pol_in,
	// one-cycle event per input
	output logic      [NUM_EXT-1:0] evt_out
);

	vip_ext_state_t state_reg;
	vip_ext_state_t state_next;

	if (NUM_EXT != `VIP_NUM_EXT) begin : g_chk
		$error("vip_ext_edge: NUM_EXT must be 5");
	end

	always_comb begin
		state_next       = state_reg;
		state_next.prev  = ext_in;
		state_next.armed = 1'b1;
		// no event until prev holds a real pin sample, so a pin that
		// idles at its active level gives no false edge after reset
		state_next.evt   = {NUM_EXT{state_reg.armed}}
			& ((pol_in & ext_in & ~state_reg.prev)
			| (~pol_in & ~ext_in & state_reg.prev));
	end

	// state register
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign evt_out = state_reg.evt;

endmodule : vip_ext_edge

// [rtl/vip_resolver.sv]
// ranks pending vectors by priority, then sub-priority, then number
// assumes the priority control word is packed eight bits per vector
module vip_resolver
	import vip_pkg::*;
#(
	parameter int NUM_VEC = `VIP_MAX_VEC
) (
	// pending vectors and priority control
	input  wire logic [NUM_VEC-1:0]              pend_in,
	input  wire logic [NUM_VEC*`VIP_SLOT_W-1:0]  prio_in,
	// winner
	output logic                                 win_valid_out,
	output logic      [`VIP_VEC_W-1:0]           win_vec_out,
	output logic      [`VIP_PRI_W-1:0]           win_pri_out,
	output logic      [`VIP_SUB_W-1:0]           win_sub_out
);

	if (NUM_VEC < 1 || NUM_VEC > `VIP_MAX_VEC) begin : g_chk
		$error("vip_resolver: NUM_VEC out of range");
	end

	// priority field of one vector slot
	function automatic logic [`VIP_PRI_W-1:0] pri_of(
		input logic [NUM_VEC*`VIP_SLOT_W-1:0] p, input int v);
		pri_of = p[v*`VIP_SLOT_W+`VIP_PRI_LSB +: `VIP_PRI_W];
	endfunction : pri_of

	// sub-priority field of one vector slot
	function automatic logic [`VIP_SUB_W-1:0] sub_of(
		input logic [NUM_VEC*`VIP_SLOT_W-1:0] p, input int v);
		sub_of = p[v*`VIP_SLOT_W+`VIP_SUB_LSB +: `VIP_SUB_W];
	endfunction : sub_of

	always_comb begin
		win_valid_out = 1'b0;
		win_vec_out   = '0;
		win_pri_out   = '0;
		win_sub_out   = '0;
		for (int v = 0; v < NUM_VEC; v++) begin
			if (pend_in[v] && pri_of(prio_in, v) != '0 &&
				(!win_valid_out ||
				{pri_of(prio_in, v), sub_of(prio_in, v)} >
				{win_pri_out, win_sub_out})) begin
				win_valid_out = 1'b1;
				win_vec_out   = `VIP_VEC_W'(v);
				win_pri_out   = pri_of(prio_in, v);
				win_sub_out   = sub_of(prio_in, v);
			end
		end
	end

endmodule : vip_resolver

// [rtl/vip_top.sv]
// vectored interrupt prioritizer: flags, enables, vector map, ranking,
// and the request presented to the processor core
// assumes all inputs synchronous to CLK_SYS_IN; software control words
// arrive as plain ports, set and clear words as one-cycle pulses
//
// Behaviour
// - rank pending events before presenting to core
// - up to 96 sources onto 64 vectors
// - single-vector and multi-vector entry modes
// - five external inputs, selectable edge polarity
// - seven priorities, four sub-priorities per vector
// - shadow set for one chosen priority
// - software flag write acts like event
// - vector table base and spacing configurable
// - core timer request 0, vector 0
// - core soft requests 1, 2 on vectors 1, 2
// - four vector slots per priority register
// - requests 4..22 grouped, vector equals request
// - serial port 1 requests share vector 23
// - requests 26..28 share vector 24
// - two-wire port 1 requests share vector 25
// - pin change request 32 on vector 26
// - absent peripherals never raise requests
module vip_top
	import vip_pkg::*;
#(
	parameter int                      NUM_IRQ      = `VIP_MAX_IRQ,
	parameter int                      NUM_VEC      = `VIP_MAX_VEC,
	parameter logic [`VIP_MAX_IRQ-1:0] PRESENT_MASK = `VIP_PRESENT_DEF
) (
	// clock and reset
	input  wire logic                        CLK_SYS_IN,
	input  wire logic                        RST_N_IN,
	// hardware events, one-cycle pulses per request number
	input  wire logic [NUM_IRQ-1:0]          PERIPH_EVT_IN,
	// external interrupt pins and edge polarity, 1 = rising
	input  wire logic [`VIP_NUM_EXT-1:0]     EXT_IN,
	input  wire logic [`VIP_NUM_EXT-1:0]     EXT_POL_IN,
	// software flag set and clear pulses, and enables
	input  wire logic [NUM_IRQ-1:0]          FLAG_SET_IN,
	input  wire logic [NUM_IRQ-1:0]          FLAG_CLR_IN,
	input  wire logic [NUM_IRQ-1:0]          ENABLE_IN,
	// priority control words, four slots of eight bits per word
	input  wire logic [NUM_VEC*8-1:0]        PRIO_CTRL_IN,
	// vector table configuration
	input  wire logic                        MULTI_VEC_IN,
	input  wire logic [31:0]                 VEC_BASE_IN,
	input  wire logic [15:0]                 VEC_SPACING_IN,
	// shadow set level and core priority level
	input  wire logic [`VIP_PRI_W-1:0]       SHADOW_PRI_IN,
	input  wire logic [`VIP_PRI_W-1:0]       CPU_PRI_IN,
	// flag state
	output logic      [NUM_IRQ-1:0]          FLAG_OUT,
	// request to the core
	output logic                             IRQ_REQ_OUT,
	output logic      [`VIP_VEC_W-1:0]       IRQ_VEC_OUT,
	output logic      [`VIP_PRI_W-1:0]       IRQ_PRI_OUT,
	output logic      [`VIP_SUB_W-1:0]       IRQ_SUB_OUT,
	output logic      [31:0]                 VEC_ADDR_OUT,
	output logic                             USE_SHADOW_OUT
);

	if (NUM_IRQ > `VIP_MAX_IRQ || NUM_IRQ <= `VIP_IRQ_PINCHG ||
		NUM_VEC > `VIP_MAX_VEC || NUM_VEC <= `VIP_VEC_PINCHG) begin : g_chk
		$error("vip_top: NUM_IRQ or NUM_VEC out of range");
	end

	vip_state_t state_reg;
	vip_state_t state_next;

	logic [`VIP_NUM_EXT-1:0] ext_evt;
	logic [NUM_VEC-1:0]      vec_pend;
	logic [NUM_IRQ-1:0]      hw_evt;
	logic                    win_valid;
	logic [`VIP_VEC_W-1:0]   win_vec;
	logic [`VIP_PRI_W-1:0]   win_pri;
	logic [`VIP_SUB_W-1:0]   win_sub;
	logic [`VIP_VEC_W-1:0]   entry_vec;

	// request number to {valid, vector}; absent numbers are invalid
	// core timer on vector 0
	function automatic logic [`VIP_VEC_W:0] irq_vec(input int irq);
		irq_vec = '0;
		if (irq < `VIP_IRQ_DIRECT_LAST) begin
			irq_vec = {1'b1, `VIP_VEC_W'(irq)};
		end else if (irq <= `VIP_IRQ_SPI1_LAST) begin
			irq_vec = {1'b1, `VIP_VEC_W'(`VIP_VEC_SPI1)};
		end else if (irq <= `VIP_IRQ_SHR24_LAST) begin
			irq_vec = {1'b1, `VIP_VEC_W'(`VIP_VEC_SHR24)};
		end else if (irq <= `VIP_IRQ_TW1_LAST) begin
			irq_vec = {1'b1, `VIP_VEC_W'(`VIP_VEC_TW1)};
		end else if (irq == `VIP_IRQ_PINCHG) begin
			irq_vec = {1'b1, `VIP_VEC_W'(`VIP_VEC_PINCHG)};
		end
	endfunction : irq_vec

	// external pin edges
	vip_ext_edge #(
		.NUM_EXT (`VIP_NUM_EXT)
	) u_ext (
		.clk_in   (CLK_SYS_IN),
		.rst_n_in (RST_N_IN),
		.ext_in   (EXT_IN),
		.pol_in   (EXT_POL_IN),
		.evt_out  (ext_evt)
	);

	always_comb begin
		hw_evt = PERIPH_EVT_IN;
		for (int i = 0; i < `VIP_NUM_EXT; i++) begin
			hw_evt[`VIP_EXT_FIRST + i*`VIP_EXT_STRIDE] =
				PERIPH_EVT_IN[`VIP_EXT_FIRST + i*`VIP_EXT_STRIDE]
				| ext_evt[i];
		end
	end

	// enabled flags make a vector pending
	// request n at word n/32, bit n mod 32
	always_comb begin
		logic [`VIP_VEC_W:0] m;
		m        = '0;
		vec_pend = '0;
		for (int n = 0; n < NUM_IRQ; n++) begin
			m = irq_vec(n);
			if (m[`VIP_VEC_W] && state_reg.flags[n] && ENABLE_IN[n]) begin
				vec_pend[m[`VIP_VEC_W-1:0]] = 1'b1;
			end
		end
	end

	vip_resolver #(
		.NUM_VEC (NUM_VEC)
	) u_rank (
		.pend_in       (vec_pend),
		.prio_in       (PRIO_CTRL_IN),
		.win_valid_out (win_valid),
		.win_vec_out   (win_vec),
		.win_pri_out   (win_pri),
		.win_sub_out   (win_sub)
	);

	assign entry_vec = MULTI_VEC_IN ? win_vec : '0;

	// next state of flags and the core request
	always_comb begin
		logic [`VIP_MAX_IRQ-1:0] set_w;
		logic [`VIP_MAX_IRQ-1:0] clr_w;
		set_w      = '0;
		clr_w      = '0;
		state_next = state_reg;
		set_w[NUM_IRQ-1:0] = hw_evt | FLAG_SET_IN;
		clr_w[NUM_IRQ-1:0] = FLAG_CLR_IN;
		// set ignores enable, set wins clear
		state_next.flags = ((state_reg.flags & ~clr_w) | set_w)
			& PRESENT_MASK;
		state_next.req    = win_valid && (win_pri > CPU_PRI_IN);
		state_next.vec    = win_vec;
		state_next.pri    = win_pri;
		state_next.sub    = win_sub;
		state_next.addr   = VEC_BASE_IN
			+ 32'(32'(entry_vec) * 32'(VEC_SPACING_IN));
		state_next.shadow = win_valid && (win_pri == SHADOW_PRI_IN);
	end

	// state register
	always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			state_reg      <= '0;
			state_reg.addr <= `VIP_ADDR_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from the state register
	assign FLAG_OUT       = state_reg.flags[NUM_IRQ-1:0];
	assign IRQ_REQ_OUT    = state_reg.req;
	assign IRQ_VEC_OUT    = state_reg.vec;
	assign IRQ_PRI_OUT    = state_reg.pri;
	assign IRQ_SUB_OUT    = state_reg.sub;
	assign VEC_ADDR_OUT   = state_reg.addr;
	assign USE_SHADOW_OUT = state_reg.shadow;

	// checks on the registered behaviour
	default clocking cb @(posedge CLK_SYS_IN);
	endclocking
	default disable iff (!RST_N_IN);

	a_req_above_cpu: assert property (
		IRQ_REQ_OUT |-> IRQ_PRI_OUT > $past(CPU_PRI_IN)
	) else $error("request not above core priority");

	a_req_pri_nonzero: assert property (
		IRQ_REQ_OUT |-> IRQ_PRI_OUT != '0
	) else $error("request forwarded at priority zero");

	a_sw_raise_flag: assert property (
		(FLAG_SET_IN & PRESENT_MASK[NUM_IRQ-1:0]) != '0 |=>
		((FLAG_OUT & $past(FLAG_SET_IN)) ==
		($past(FLAG_SET_IN) & PRESENT_MASK[NUM_IRQ-1:0]))
	) else $error("software raise did not set flag");

	a_absent_clear: assert property (
		(FLAG_OUT & ~PRESENT_MASK[NUM_IRQ-1:0]) == '0
	) else $error("absent source flag set");

	// event sets flag even when disabled and cleared
	a_event_beats_clr: assert property (
		PERIPH_EVT_IN[0] && PRESENT_MASK[0] |=> FLAG_OUT[0]
	) else $error("core timer event lost");

	// rising edge on pin 0 with rising polarity sets request 3 two cycles later
	a_ext_edge_flag: assert property (
		EXT_POL_IN[0] && EXT_IN[0] && !$past(EXT_IN[0]) &&
		$past(RST_N_IN) && PRESENT_MASK[`VIP_EXT_FIRST] |=>
		##1 FLAG_OUT[`VIP_EXT_FIRST]
	) else $error("external edge did not set flag");

	// falling edge on pin 0 with falling polarity
	a_ext_fall_flag: assert property (
		!EXT_POL_IN[0] && !EXT_IN[0] && $past(EXT_IN[0]) &&
		$past(RST_N_IN) && PRESENT_MASK[`VIP_EXT_FIRST] |=>
		##1 FLAG_OUT[`VIP_EXT_FIRST]
	) else $error("falling edge did not set flag");

	// single mode enters at entry zero
	a_single_entry: assert property (
		IRQ_REQ_OUT && !$past(MULTI_VEC_IN) |->
		VEC_ADDR_OUT == $past(VEC_BASE_IN)
	) else $error("single mode entry address wrong");

	// a request needs an enabled pending source
	a_req_has_source: assert property (
		IRQ_REQ_OUT |->
		$past((FLAG_OUT & ENABLE_IN) != '0)
	) else $error("request without a pending source");

	// clear without a set drops the flag
	a_flag_clear: assert property (
		FLAG_CLR_IN[0] && !FLAG_SET_IN[0] && !PERIPH_EVT_IN[0] |=>
		!FLAG_OUT[0]
	) else $error("flag clear lost");

	a_flag_hold: assert property (
		FLAG_OUT[0] && !FLAG_CLR_IN[0] |=>
		FLAG_OUT[0]
	) else $error("flag dropped without clear");

	// enabled pending vector 0 above core level raises a request
	a_pend_forwarded: assert property (
		FLAG_OUT[0] && ENABLE_IN[0] &&
		PRIO_CTRL_IN[4:2] > CPU_PRI_IN |=> IRQ_REQ_OUT
	) else $error("pending request above core level not forwarded");

	// vector 0 only from the core timer
	a_timer_vec0: assert property (
		IRQ_REQ_OUT && IRQ_VEC_OUT == 6'h00 |->
		$past(FLAG_OUT[0] && ENABLE_IN[0])
	) else $error("vector 0 without core timer request");

	// vector 1 only from the first soft request
	a_soft_vec1: assert property (
		IRQ_REQ_OUT && IRQ_VEC_OUT == 6'h01 |->
		$past(FLAG_OUT[1] && ENABLE_IN[1])
	) else $error("vector 1 without soft request");

	// vector 23 only from serial port 1 requests
	a_spi1_shared: assert property (
		IRQ_REQ_OUT && IRQ_VEC_OUT == 6'h17 |->
		$past((FLAG_OUT[25:23] & ENABLE_IN[25:23]) != 3'h0)
	) else $error("vector 23 without serial port 1 request");

	// vector 24 only from requests 26 to 28
	a_shr24_shared: assert property (
		IRQ_REQ_OUT && IRQ_VEC_OUT == 6'h18 |->
		$past((FLAG_OUT[28:26] & ENABLE_IN[28:26]) != 3'h0)
	) else $error("vector 24 without shared request");

	// vector 25 only from two-wire port 1 requests
	a_tw1_shared: assert property (
		IRQ_REQ_OUT && IRQ_VEC_OUT == 6'h19 |->
		$past((FLAG_OUT[31:29] & ENABLE_IN[31:29]) != 3'h0)
	) else $error("vector 25 without two-wire request");

	// vector 26 only from the pin change request
	a_pinchg_vec: assert property (
		IRQ_REQ_OUT && IRQ_VEC_OUT == 6'h1a |->
		$past(FLAG_OUT[32] && ENABLE_IN[32])
	) else $error("vector 26 without pin change request");

	// first slot of a control word
	a_slot0_fields: assert property (
		IRQ_REQ_OUT && IRQ_VEC_OUT == 6'h00 |->
		IRQ_PRI_OUT == $past(PRIO_CTRL_IN[4:2]) &&
		IRQ_SUB_OUT == $past(PRIO_CTRL_IN[1:0])
	) else $error("slot 0 fields wrong");

	// last slot of a control word
	a_slot3_fields: assert property (
		IRQ_REQ_OUT && IRQ_VEC_OUT == 6'h03 |->
		IRQ_PRI_OUT == $past(PRIO_CTRL_IN[28:26]) &&
		IRQ_SUB_OUT == $past(PRIO_CTRL_IN[25:24])
	) else $error("slot 3 fields wrong");

	// forwarded vectors lie in the map
	a_vec_in_map: assert property (
		IRQ_REQ_OUT |-> IRQ_VEC_OUT <= `VIP_VEC_W'(`VIP_VEC_PINCHG)
	) else $error("vector outside the map");

	// entry address from base and spacing
	a_entry_addr: assert property (
		IRQ_REQ_OUT |-> VEC_ADDR_OUT == $past(VEC_BASE_IN) +
		32'(32'($past(MULTI_VEC_IN) ? IRQ_VEC_OUT : '0) *
		32'($past(VEC_SPACING_IN)))
	) else $error("entry address wrong");

	a_shadow_level: assert property (
		IRQ_REQ_OUT |->
		USE_SHADOW_OUT == (IRQ_PRI_OUT == $past(SHADOW_PRI_IN))
	) else $error("shadow select wrong");

endmodule : vip_top

// [tb/vip_core_model.sv]
// behavioural processor core facing the interrupt prioritizer
// assumes request, vector and priority registered on the system clock
module vip_core_model
	import vip_pkg::*;
(
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	// request from the prioritizer
	input  wire logic       req_in,
	input  wire logic [5:0] vec_in,
	input  wire logic [2:0] pri_in,
	// bench control: base level, accept and return
	input  wire logic [2:0] base_pri_in,
	input  wire logic       take_en_in,
	input  wire logic       ret_in,
	// level seen by the prioritizer and last vector taken
	output logic      [2:0] cpu_pri_out,
	output logic      [5:0] taken_vec_out
);
	timeunit 1ns;
	timeprecision 1ps;

	logic       active_reg;
	logic [2:0] level_reg;

	// enter a handler at the request level, leave it on return
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			active_reg    <= 1'b0;
			level_reg     <= 3'h0;
			taken_vec_out <= 6'h00;
		end else if (ret_in) begin
			active_reg <= 1'b0;
		end else if (take_en_in && req_in && !active_reg) begin
			active_reg    <= 1'b1;
			level_reg     <= pri_in;
			taken_vec_out <= vec_in;
		end
	end

	// inside a handler the core runs at the handler level
	assign cpu_pri_out = active_reg ? level_reg : base_pri_in;
endmodule : vip_core_model

// [tb/testbench.sv]
// self-checking bench of the interrupt prioritizer with a core model
// assumes default parameters: 96 requests, 64 vectors, requests 0..32
module testbench
	import vip_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic          clk, rst_n, multi, take, ret, req, shadow;
	logic [95:0]   evt, fset, fclr, en, flag;
	logic [511:0]  prio;
	logic [4:0]    ext, pol;
	logic [31:0]   base, addr;
	logic [15:0]   spc;
	logic [5:0]    vec, tvec;
	logic [2:0]    shd, bpri, cpu, pri;
	logic [1:0]    sub;
	int            bad_count, checks;

	vip_top vip_top_i (.CLK_SYS_IN(clk), .RST_N_IN(rst_n),
		.PERIPH_EVT_IN(evt), .EXT_IN(ext), .EXT_POL_IN(pol),
		.FLAG_SET_IN(fset), .FLAG_CLR_IN(fclr), .ENABLE_IN(en),
		.PRIO_CTRL_IN(prio), .MULTI_VEC_IN(multi), .VEC_BASE_IN(base),
		.VEC_SPACING_IN(spc), .SHADOW_PRI_IN(shd), .CPU_PRI_IN(cpu),
		.FLAG_OUT(flag), .IRQ_REQ_OUT(req), .IRQ_VEC_OUT(vec),
		.IRQ_PRI_OUT(pri), .IRQ_SUB_OUT(sub), .VEC_ADDR_OUT(addr),
		.USE_SHADOW_OUT(shadow));

	vip_core_model vip_core_model_i (.clk_in(clk), .rst_n_in(rst_n),
		.req_in(req), .vec_in(vec), .pri_in(pri), .base_pri_in(bpri),
		.take_en_in(take), .ret_in(ret), .cpu_pri_out(cpu),
		.taken_vec_out(tvec));

	// 50 MHz system clock
	always #10 clk = ~clk;

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic chk(input logic [95:0] got, input logic [95:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// clear every flag and drop enables and priorities
	task automatic clean;
		@(posedge clk);
		fclr <= '1;
		en   <= '0;
		prio <= '0;
		fset <= '0;
		evt  <= '0;
		cyc(1);
		fclr <= '0;
		cyc(2);
	endtask : clean

	// vector number that a request maps onto
	function automatic int vec_of(input int n);
		if (n <= 22) return n;
		if (n <= 25) return 23;
		if (n <= 28) return 24;
		if (n <= 31) return 25;
		return 26;
	endfunction : vec_of

	task automatic t_map;
		for (int n = 0; n <= 32; n++) begin
			prio[vec_of(n)*8 +: 8] <= 8'h04;
			en[n]   <= 1'b1;
			fset[n] <= 1'b1;
			cyc(1);
			fset <= '0;
			cyc(1);
			#1;
			chk(flag, 96'h1 << n);
			chk(req, 1);
			chk(vec, vec_of(n));
			clean();
		end
		$display("map test done");
	endtask : t_map

	task automatic rank(input int va, input logic [2:0] pa,
		input logic [1:0] sa, input int vb, input logic [2:0] pb,
		input logic [1:0] sb, input int w);
		prio[va*8 +: 8] <= {3'h0, pa, sa};
		prio[vb*8 +: 8] <= {3'h0, pb, sb};
		en[va]   <= 1'b1;
		en[vb]   <= 1'b1;
		fset[va] <= 1'b1;
		fset[vb] <= 1'b1;
		cyc(1);
		fset <= '0;
		cyc(1);
		#1;
		chk(req, 1);
		chk(vec, w);
		clean();
	endtask : rank

	// core level threshold with handler entry and return
	task automatic t_level;
		prio[6*8 +: 8] <= 8'h10;
		en[6]   <= 1'b1;
		fset[6] <= 1'b1;
		bpri    <= 3'h4;
		cyc(1);
		fset <= '0;
		cyc(1);
		#1;
		chk(req, 0);
		chk(vec, 6);
		cyc(1);
		bpri <= 3'h3;
		cyc(1);
		#1;
		chk(req, 1);
		chk(pri, 3'h4);
		cyc(1);
		take <= 1'b1;
		cyc(1);
		take <= 1'b0;
		cyc(1);
		#1;
		chk(req, 0);
		chk(tvec, 6);
		cyc(1);
		ret <= 1'b1;
		cyc(1);
		ret <= 1'b0;
		cyc(1);
		#1;
		chk(req, 1);
		bpri <= 3'h0;
		clean();
		$display("level test done");
	endtask : t_level

	// both polarities on all five pins
	task automatic t_ext;
		for (int i = 0; i < 5; i++) begin
			for (int p = 0; p < 2; p++) begin
				cyc(1);
				pol[i] <= p[0];
				ext[i] <= ~p[0];
				cyc(4);
				clean();
				ext[i] <= p[0];
				cyc(3);
				#1;
				chk(flag[3+4*i], 1);
				cyc(1);
				fclr   <= '1;
				ext[i] <= ~p[0];
				cyc(1);
				fclr <= '0;
				cyc(3);
				#1;
				chk(flag[3+4*i], 0);
			end
		end
		$display("external test done");
	endtask : t_ext

	task automatic t_entry;
		prio[9*8 +: 8] <= 8'h09;
		en[9]   <= 1'b1;
		fset[9] <= 1'b1;
		base    <= 32'h1000_0200;
		spc     <= 16'h0020;
		multi   <= 1'b1;
		shd     <= 3'h2;
		cyc(1);
		fset <= '0;
		cyc(1);
		#1;
		chk(addr, 32'h1000_0320);
		chk(shadow, 1);
		chk(sub, 1);
		cyc(1);
		multi <= 1'b0;
		shd   <= 3'h3;
		cyc(1);
		#1;
		chk(addr, 32'h1000_0200);
		chk(shadow, 0);
		clean();
		$display("entry test done");
	endtask : t_entry

	// absent source, disabled flag, set over clear
	task automatic t_misc;
		prio[4*8 +: 8] <= 8'h14;
		evt[4]  <= 1'b1;
		fset[40] <= 1'b1;
		en[40]  <= 1'b1;
		fset[5] <= 1'b1;
		fclr[5] <= 1'b1;
		cyc(1);
		evt  <= '0;
		fset <= '0;
		fclr <= '0;
		cyc(1);
		#1;
		chk(flag[4], 1);
		chk(flag[40], 0);
		chk(flag[5], 1);
		chk(req, 0);
		cyc(1);
		en[4] <= 1'b1;
		cyc(1);
		#1;
		chk(req, 1);
		chk(vec, 4);
		clean();
		$display("misc test done");
	endtask : t_misc

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop

	// watchdog against a hang
	initial begin
		#100_000;
		bad_count++;
		report_and_stop();
	end

	// main sequence
	initial begin
		{clk, multi, take, ret} = '0;
		{evt, fset, fclr, en, prio} = '0;
		// pins idle at their active level through reset
		{ext, pol} = '1;
		{base, spc, shd, bpri} = '0;
		bad_count = 0;
		checks    = 0;
		rst_n     = 1'b0;
		cyc(16);
		rst_n <= 1'b1;
		cyc(2);
		#1;
		chk(flag, 0);
		chk(req, 0);
		clean();
		t_map();
		rank(5, 3'h3, 2'h0, 9, 3'h4, 2'h0, 9);
		rank(5, 3'h4, 2'h1, 9, 3'h4, 2'h3, 9);
		rank(5, 3'h4, 2'h3, 9, 3'h4, 2'h3, 5);
		rank(12, 3'h7, 2'h0, 4, 3'h6, 2'h3, 12);
		rank(5, 3'h0, 2'h3, 9, 3'h1, 2'h0, 9);
		$display("rank test done");
		t_level();
		t_ext();
		t_entry();
		t_misc();
		report_and_stop();
	end
endmodule : testbench
